//--- srh_pkg.sv
// constants, codes and reset values shared by the status reporting hierarchy
package srh_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned PART_W    = 16;   // width of each part
  localparam int unsigned STDEV_W   = 8;    // standard event register width
  localparam int unsigned NUM_GRP   = 5;    // sixteen-bit groups in the tree
  localparam logic [15:0] USE_MASK  = 16'h7fff;  // usable bits, bit 15 zero
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RISE_RST  = 16'h7fff;
  localparam logic [15:0] FALL_RST  = 16'h0000;
  localparam logic [15:0] EVT_RST   = 16'h0000;
  localparam logic [15:0] MASK_RST  = 16'h0000;
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  // ---------------------------------------------------------------
  // part codes of a group
  // ---------------------------------------------------------------
  localparam logic [2:0] PART_LIVE  = 3'h0;
  localparam logic [2:0] PART_RISE  = 3'h1;
  localparam logic [2:0] PART_FALL  = 3'h2;
  localparam logic [2:0] PART_EVT   = 3'h3;
  localparam logic [2:0] PART_MASK  = 3'h4;
  // ---------------------------------------------------------------
  // group codes; common level uses its own part codes
  // ---------------------------------------------------------------
  localparam logic [2:0] GRP_OPER   = 3'h0;
  localparam logic [2:0] GRP_QUES   = 3'h1;
  localparam logic [2:0] GRP_LIM1   = 3'h2;
  localparam logic [2:0] GRP_LIM2   = 3'h3;
  localparam logic [2:0] GRP_GRPA   = 3'h4;
  localparam logic [2:0] GRP_COMMON = 3'h5;
  localparam logic [2:0] COM_SBYTE  = 3'h0;
  localparam logic [2:0] COM_RQMSK  = 3'h1;
  localparam logic [2:0] COM_PPMSK  = 3'h2;
  localparam logic [2:0] COM_STDEV  = 3'h3;
  localparam logic [2:0] COM_EVMSK  = 3'h4;
  localparam logic [2:0] COM_INDIV  = 3'h5;
  // ---------------------------------------------------------------
  // summary byte bit positions
  // ---------------------------------------------------------------
  localparam int unsigned BIT_ERRQ    = 2;
  localparam int unsigned BIT_QUES    = 3;
  localparam int unsigned BIT_MSGA    = 4;
  localparam int unsigned BIT_EVSUM   = 5;
  localparam int unsigned BIT_MASTER  = 6;
  localparam int unsigned BIT_OPER    = 7;
  localparam logic [7:0]  MASTER_MASK = 8'h40;
  // ---------------------------------------------------------------
  // questionable live bits fed by lower groups
  // ---------------------------------------------------------------
  localparam int unsigned QUES_LIM1 = 9;
  localparam int unsigned QUES_LIM2 = 10;
  localparam int unsigned QUES_GRPA = 11;
endpackage

//--- srh_group.sv
// one sixteen-bit status register group with five parts
`timescale 1ns/1ns
`default_nettype none
module srh_group (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [15:0] live_in,
  input  wire logic        acc_en,
  input  wire logic        acc_write,
  input  wire logic [2:0]  acc_part,
  input  wire logic [15:0] acc_wdata,
  output logic      [15:0] acc_rdata,
  output logic             summary
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] live;   // live state, sampled each cycle
    logic [15:0] rise;   // rising transition filter
    logic [15:0] fall;   // falling transition filter
    logic [15:0] evt;    // latched events
    logic [15:0] mask;   // summary mask
  } srh_grp_t;

  srh_grp_t    st_ff;      // registered state
  srh_grp_t    nxt_st;     // next state
  logic [15:0] cond_now;   // usable live inputs
  logic [15:0] rise_hit;   // filtered rising edges
  logic [15:0] fall_hit;   // filtered falling edges
  logic        clr_evt;    // clearing read of events
  logic        wr_ok;      // write strobe

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_st   = st_ff;
    cond_now = live_in & srh_pkg::USE_MASK;
    rise_hit = cond_now & ~st_ff.live & st_ff.rise;
    fall_hit = ~cond_now & st_ff.live & st_ff.fall;
    wr_ok    = acc_en && acc_write;
    clr_evt  = acc_en && !acc_write && (acc_part == srh_pkg::PART_EVT);
    // live part only follows hardware, writes never reach it
    nxt_st.live = cond_now;
    if (wr_ok && (acc_part == srh_pkg::PART_RISE))
    begin
      nxt_st.rise = acc_wdata & srh_pkg::USE_MASK;
    end
    else if (wr_ok && (acc_part == srh_pkg::PART_FALL))
    begin
      nxt_st.fall = acc_wdata & srh_pkg::USE_MASK;
    end
    else if (wr_ok && (acc_part == srh_pkg::PART_MASK))
    begin
      nxt_st.mask = acc_wdata & srh_pkg::USE_MASK;
    end
    // new edges win over a clearing read in the same cycle
    nxt_st.evt = (st_ff.evt & ~{16{clr_evt}}) | rise_hit | fall_hit;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st_ff <= '{16'h0000, srh_pkg::RISE_RST, srh_pkg::FALL_RST,
                 srh_pkg::EVT_RST, srh_pkg::MASK_RST};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // read mux and summary
  // ---------------------------------------------------------------
  always_comb
  begin
    if (acc_part == srh_pkg::PART_LIVE)
      acc_rdata = st_ff.live;
    else if (acc_part == srh_pkg::PART_RISE)
      acc_rdata = st_ff.rise;
    else if (acc_part == srh_pkg::PART_FALL)
      acc_rdata = st_ff.fall;
    else if (acc_part == srh_pkg::PART_EVT)
      acc_rdata = st_ff.evt;
    else if (acc_part == srh_pkg::PART_MASK)
      acc_rdata = st_ff.mask;
    else
      acc_rdata = 16'h0000;   // unused part codes read zero
  end

  assign summary = |(st_ff.evt & st_ff.mask);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_evt_read;
    acc_en && !acc_write && (acc_part == srh_pkg::PART_EVT);
  endsequence

  a_bit15_zero:
  assert property (@(posedge clk) disable iff (!resetn)
    !(st_ff.live[15] | st_ff.rise[15] | st_ff.fall[15] | st_ff.evt[15] | st_ff.mask[15]))
    else $error("bit 15 of a part is set");
  a_rise_latch:
  assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |=> ((st_ff.evt & $past(rise_hit)) == $past(rise_hit)))
    else $error("filtered rising edge not latched");
  a_fall_latch:
  assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |=> ((st_ff.evt & $past(fall_hit)) == $past(fall_hit)))
    else $error("filtered falling edge not latched");
  a_evt_clear:
  assert property (@(posedge clk) disable iff (!resetn)
    s_evt_read ##0 ((rise_hit == 16'h0000) && (fall_hit == 16'h0000)) |=> (st_ff.evt == 16'h0000))
    else $error("event part not cleared by read");
  a_live_follow:
  assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |=> (st_ff.live == ($past(live_in) & srh_pkg::USE_MASK)))
    else $error("live part does not follow input");
  a_mask_keep:
  assert property (@(posedge clk) disable iff (!resetn)
    !(acc_en && acc_write && (acc_part == srh_pkg::PART_MASK)) |=> $stable(st_ff.mask))
    else $error("mask changed without a write");
endmodule // srh_group
`default_nettype wire

//--- srh_top.sv
// status reporting hierarchy: five groups, event register and summary byte
`timescale 1ns/1ns
`default_nettype none
module srh_top (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [15:0] oper_status_in,
  input  wire logic [15:0] ques_status_in,
  input  wire logic [15:0] lim1_status_in,
  input  wire logic [15:0] lim2_status_in,
  input  wire logic [15:0] hw_fail_in,
  input  wire logic [7:0]  std_event_in,
  input  wire logic        msg_avail_in,
  input  wire logic        err_queue_nonempty_in,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [2:0]  cmd_group,
  input  wire logic [2:0]  cmd_part,
  input  wire logic [15:0] cmd_wdata,
  output logic             rsp_valid,
  output logic      [15:0] rsp_data,
  output logic      [7:0]  status_byte,
  output logic             service_request,
  output logic             srq_event,
  output logic             indiv_flag
);
  // ---------------------------------------------------------------
  // state of the common level
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  sbyte;     // summary status byte
    logic [7:0]  rq_mask;   // service request mask
    logic [7:0]  pp_mask;   // parallel poll mask
    logic [7:0]  std_ev;    // standard event register
    logic [7:0]  ev_mask;   // standard event mask
    logic        rsp_vld;   // answer strobe
    logic [15:0] rsp;       // answer word
    logic        srq_evt;   // one-cycle request pulse
    logic        indiv;     // individual status flag
  } srh_top_t;

  srh_top_t    st_ff;                        // registered state
  srh_top_t    nxt_st;                       // next state
  logic [15:0] live_vec [srh_pkg::NUM_GRP];  // live inputs per group
  logic [15:0] rd_vec   [srh_pkg::NUM_GRP];  // read data per group
  logic [4:0]  sum_vec;                      // group summaries
  logic [4:0]  grp_sel;                      // group access enables
  logic        com_sel;                      // common level selected
  logic        rd_req;                       // read request this cycle
  logic        wr_req;                       // write request this cycle
  logic        evsum_now;                    // event summary
  logic [7:0]  sbyte_low;                    // summary byte without bit 6
  logic [7:0]  sbyte_new;                    // full next summary byte

  // ---------------------------------------------------------------
  // group access decode
  // ---------------------------------------------------------------
  function automatic logic [4:0] grp_decode(input logic [2:0] g, input logic v);
    logic [4:0] d;
    d = 5'h00;
    if (v && (g < srh_pkg::GRP_COMMON))
      d[g] = 1'b1;
    return d;
  endfunction

  function automatic logic [15:0] byte_word(input logic [7:0] b);
    return {8'h00, b};
  endfunction

  assign grp_sel = grp_decode(cmd_group, cmd_valid);
  assign com_sel = cmd_valid && (cmd_group == srh_pkg::GRP_COMMON);
  assign rd_req  = cmd_valid && !cmd_write;
  assign wr_req  = cmd_valid && cmd_write;

  // ---------------------------------------------------------------
  // live inputs: lower summaries land in questionable bits
  // ---------------------------------------------------------------
  always_comb
  begin
    live_vec[srh_pkg::GRP_OPER] = oper_status_in;
    live_vec[srh_pkg::GRP_QUES] = ques_status_in;
    live_vec[srh_pkg::GRP_QUES][srh_pkg::QUES_LIM1] = sum_vec[srh_pkg::GRP_LIM1];
    live_vec[srh_pkg::GRP_QUES][srh_pkg::QUES_LIM2] = sum_vec[srh_pkg::GRP_LIM2];
    live_vec[srh_pkg::GRP_QUES][srh_pkg::QUES_GRPA] = sum_vec[srh_pkg::GRP_GRPA];
    live_vec[srh_pkg::GRP_LIM1] = lim1_status_in;
    live_vec[srh_pkg::GRP_LIM2] = lim2_status_in;
    live_vec[srh_pkg::GRP_GRPA] = hw_fail_in;
  end

  // ---------------------------------------------------------------
  // the five sixteen-bit groups
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < srh_pkg::NUM_GRP; gi++)
    begin : g_grp
      srh_group u_grp (
        .clk       (clk),
        .resetn    (resetn),
        .live_in   (live_vec[gi]),
        .acc_en    (grp_sel[gi]),
        .acc_write (cmd_write),
        .acc_part  (cmd_part),
        .acc_wdata (cmd_wdata),
        .acc_rdata (rd_vec[gi]),
        .summary   (sum_vec[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // next state of the common level
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_st    = st_ff;
    // event summary is a level: standard events stay set until read
    evsum_now = |(st_ff.std_ev & st_ff.ev_mask);
    // build the byte from live summaries; bits 0 and 1 stay zero
    sbyte_low = 8'h00;
    sbyte_low[srh_pkg::BIT_ERRQ]  = err_queue_nonempty_in;
    sbyte_low[srh_pkg::BIT_QUES]  = sum_vec[srh_pkg::GRP_QUES];
    sbyte_low[srh_pkg::BIT_MSGA]  = msg_avail_in;
    sbyte_low[srh_pkg::BIT_EVSUM] = evsum_now;
    sbyte_low[srh_pkg::BIT_OPER]  = sum_vec[srh_pkg::GRP_OPER];
    sbyte_new = sbyte_low;
    // master summary ignores mask bit 6, else it would feed on itself
    sbyte_new[srh_pkg::BIT_MASTER] = |(sbyte_low & st_ff.rq_mask & ~srh_pkg::MASTER_MASK);
    nxt_st.sbyte = sbyte_new;
    // request pulse on a masked rising bit; a bit already high sends none
    nxt_st.srq_evt = |(sbyte_low & ~st_ff.sbyte & st_ff.rq_mask & ~srh_pkg::MASTER_MASK);
    // parallel poll flag includes bit 6
    nxt_st.indiv = |(sbyte_new & st_ff.pp_mask);
    // standard events: new events win over a clearing read
    if (com_sel && rd_req && (cmd_part == srh_pkg::COM_STDEV))
      nxt_st.std_ev = std_event_in;
    else
      nxt_st.std_ev = st_ff.std_ev | std_event_in;
    // writes to the common masks; byte, events and flag ignore writes
    if (com_sel && wr_req && (cmd_part == srh_pkg::COM_RQMSK))
    begin
      nxt_st.rq_mask = cmd_wdata[7:0];
    end
    else if (com_sel && wr_req && (cmd_part == srh_pkg::COM_PPMSK))
    begin
      nxt_st.pp_mask = cmd_wdata[7:0];
    end
    else if (com_sel && wr_req && (cmd_part == srh_pkg::COM_EVMSK))
    begin
      nxt_st.ev_mask = cmd_wdata[7:0];
    end
    // answer one cycle after each read
    nxt_st.rsp_vld = rd_req;
    nxt_st.rsp     = st_ff.rsp;
    if (!rd_req)
    begin
      nxt_st.rsp = st_ff.rsp;              // hold last answer
    end
    else if (grp_sel != 5'h00)
    begin
      nxt_st.rsp = rd_vec[cmd_group];      // group part
    end
    else if (com_sel && (cmd_part == srh_pkg::COM_SBYTE))
    begin
      // reading the byte leaves it alone: its bits are live summaries
      nxt_st.rsp = byte_word(st_ff.sbyte);
    end
    else if (com_sel && (cmd_part == srh_pkg::COM_RQMSK))
    begin
      // mask bit 6 is stored and read back although it gates nothing
      nxt_st.rsp = byte_word(st_ff.rq_mask);
    end
    else if (com_sel && (cmd_part == srh_pkg::COM_PPMSK))
    begin
      nxt_st.rsp = byte_word(st_ff.pp_mask);
    end
    else if (com_sel && (cmd_part == srh_pkg::COM_STDEV))
    begin
      // value before the clear that this same read performs
      nxt_st.rsp = byte_word(st_ff.std_ev);
    end
    else if (com_sel && (cmd_part == srh_pkg::COM_EVMSK))
    begin
      nxt_st.rsp = byte_word(st_ff.ev_mask);
    end
    else if (com_sel && (cmd_part == srh_pkg::COM_INDIV))
    begin
      nxt_st.rsp = {15'h0000, st_ff.indiv};
    end
    else
    begin
      nxt_st.rsp = 16'h0000;               // unmapped reads return zero
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st_ff <= '{srh_pkg::BYTE_RST, srh_pkg::BYTE_RST, srh_pkg::BYTE_RST,
                 srh_pkg::BYTE_RST, srh_pkg::BYTE_RST, 1'b0, 16'h0000,
                 1'b0, 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs straight from the state register
  // ---------------------------------------------------------------
  assign rsp_valid       = st_ff.rsp_vld;
  assign rsp_data        = st_ff.rsp;
  // no output passes through logic after the register
  assign status_byte     = st_ff.sbyte;
  assign service_request = st_ff.sbyte[srh_pkg::BIT_MASTER];
  assign srq_event       = st_ff.srq_evt;
  assign indiv_flag      = st_ff.indiv;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // a masked byte bit, other than the master bit, rising one cycle on
  sequence s_masked_rise;
    ##1 (|(status_byte & ~$past(status_byte) & $past(st_ff.rq_mask) & ~srh_pkg::MASTER_MASK));
  endsequence

  a_master_value:
  assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |=> (service_request == |($past(sbyte_low) & $past(st_ff.rq_mask) & ~srh_pkg::MASTER_MASK)))
    else $error("master summary wrong");

  a_srq_pulse:
  assert property (@(posedge clk) disable iff (!resetn)
    (st_ff.rq_mask == $past(st_ff.rq_mask)) ##0 s_masked_rise |-> srq_event)
    else $error("masked rise gave no request pulse");

  a_indiv_value:
  assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |=> (indiv_flag == |(status_byte & $past(st_ff.pp_mask))))
    else $error("status flag wrong");

  a_msg_follow:
  assert property (@(posedge clk) disable iff (!resetn)
    msg_avail_in |=> status_byte[srh_pkg::BIT_MSGA])
    else $error("message available not shown");

  a_evsum_set:
  assert property (@(posedge clk) disable iff (!resetn)
    |(std_event_in & st_ff.ev_mask) && !wr_req |=> ##1 status_byte[srh_pkg::BIT_EVSUM])
    else $error("masked standard event did not set summary");

  a_stdev_keep:
  assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |=> ((st_ff.std_ev & $past(std_event_in)) == $past(std_event_in)))
    else $error("standard event lost");

  a_rsp_timing:
  assert property (@(posedge clk) disable iff (!resetn)
    rd_req |=> rsp_valid)
    else $error("read got no answer");

  // questionable summary must reach the byte one edge later
  a_ques_carry:
  assert property (@(posedge clk) disable iff (!resetn)
    sum_vec[srh_pkg::GRP_QUES] |=> status_byte[srh_pkg::BIT_QUES])
    else $error("questionable summary not shown");

  // error queue state is shown beside the registers
  a_errq_follow:
  assert property (@(posedge clk) disable iff (!resetn)
    err_queue_nonempty_in |=> status_byte[srh_pkg::BIT_ERRQ])
    else $error("error queue state not shown");
endmodule // srh_top
`default_nettype wire

//--- srh_ctrl.sv
// controller model: one command at a time, answer captured
`timescale 1ns/1ns
`default_nettype none
module srh_ctrl (
  input  wire logic        clk,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [2:0]       cmd_group,
  output logic [2:0]       cmd_part,
  output logic [15:0]      cmd_wdata
);
  logic        got_rsp;  // answer pulse seen
  logic [15:0] got_data; // captured answer
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_group = 3'h0;
    cmd_part  = 3'h0;
    cmd_wdata = 16'h0000;
  end
  // command held over one edge; released direction and data lines show the inverse
  task automatic xfer(input logic w, input logic [2:0] g, input logic [2:0] p, input logic [15:0] d);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_group = g;
    cmd_part  = p;
    cmd_wdata = d;
    @(negedge clk);
    // answer stands only from the taking edge to the next one
    got_rsp   = rsp_valid;
    got_data  = rsp_data;
    cmd_valid = 1'b0;
    cmd_write = ~w;
    cmd_wdata = ~d;
    if (!w)
    begin
      @(negedge clk);
    end
  endtask
endmodule // srh_ctrl
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the status reporting hierarchy
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end
module tb_top;
  logic        clk = 1'b0;                 // 10 MHz clock
  logic        resetn;                     // synchronous reset, active low
  logic [15:0] st [5];                     // live inputs of the groups
  logic [7:0]  std_ev;                     // standard event pulses
  logic        msg_av, errq;               // buffer and error queue flags
  logic        cmd_valid, cmd_write;       // command strobe and direction
  logic [2:0]  cmd_group, cmd_part;        // command target
  logic [15:0] cmd_wdata, rsp_data;        // command data and answer
  logic        rsp_valid, service_request, srq_event, indiv_flag;
  logic [7:0]  status_byte;                // summary byte
  int          num_errors = 0;
  int          n_compared = 0;
  int          seed = 32'hf3d3_02d5;
  logic [15:0] rf, ff, ev, prv;            // expectation of one group
  always #50 clk = ~clk;
  srh_top uut (.clk(clk), .resetn(resetn), .oper_status_in(st[0]), .ques_status_in(st[1]),
    .lim1_status_in(st[2]), .lim2_status_in(st[3]), .hw_fail_in(st[4]), .std_event_in(std_ev),
    .msg_avail_in(msg_av), .err_queue_nonempty_in(errq), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_group(cmd_group), .cmd_part(cmd_part), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .status_byte(status_byte), .service_request(service_request),
    .srq_event(srq_event), .indiv_flag(indiv_flag));
  srh_ctrl ctl (.clk(clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_group(cmd_group), .cmd_part(cmd_part), .cmd_wdata(cmd_wdata));
  // expected event part after one live update
  function automatic logic [15:0] ev_upd(input logic [15:0] e, o, n, r, f);
    return e | (((n & ~o & r) | (o & ~n & f)) & 16'h7fff);
  endfunction
  task automatic wr(input logic [2:0] g, input logic [2:0] p, input logic [15:0] d);
    ctl.xfer(1'b1, g, p, d);
  endtask
  task automatic rd(input logic [2:0] g, input logic [2:0] p, input logic [15:0] e);
    ctl.xfer(1'b0, g, p, 16'h0000);
    `CHK({ctl.got_rsp, ctl.got_data}, {1'b1, e})
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task summarize;
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    summarize();
  end
  initial
  begin
    resetn = 1'b0;
    foreach (st[i]) st[i] = 16'h0000;
    std_ev = 8'h00;
    msg_av = 1'b0;
    errq = 1'b0;
    tick(12);
    resetn = 1'b1;
    `CHK({status_byte, service_request, indiv_flag}, 10'h000)
    // reset values, access kinds, read-back of every group
    for (int g = 0; g < 5; g++)
    begin
      rd(3'(g), 3'h1, 16'h7fff);
      rd(3'(g), 3'h2, 16'h0000);
      rd(3'(g), 3'h4, 16'h0000);
      rf = 16'($random(seed));
      ff = 16'($random(seed));
      ev = (g == 0) ? 16'hffff : 16'($random(seed));
      wr(3'(g), 3'h1, rf);
      wr(3'(g), 3'h2, ff);
      wr(3'(g), 3'h4, ev);
      wr(3'(g), 3'h0, 16'hffff);
      wr(3'(g), 3'h3, 16'hffff);
      rd(3'(g), 3'h1, rf & 16'h7fff);
      rd(3'(g), 3'h2, ff & 16'h7fff);
      rd(3'(g), 3'h4, ev & 16'h7fff);
      rd(3'(g), 3'h4, ev & 16'h7fff);
      rd(3'(g), 3'h0, 16'h0000);
      rd(3'(g), 3'h3, 16'h0000);
      wr(3'(g), 3'h4, 16'h0000);
    end
    // random live traffic through the transition filters
    rf = 16'($random(seed));
    ff = 16'($random(seed));
    ev = 16'h0000;
    prv = 16'h0000;
    wr(3'h0, 3'h1, rf);
    wr(3'h0, 3'h2, ff);
    for (int k = 0; k < 40; k++)
    begin
      tick(1);
      st[0] = (k % 8 == 3) ? 16'hffff : (k % 8 == 7) ? 16'h0000 : 16'($random(seed));
      ev = ev_upd(ev, prv, st[0], rf, ff);
      prv = st[0];
    end
    tick(1);
    rd(3'h0, 3'h0, st[0] & 16'h7fff);
    rd(3'h0, 3'h3, ev);
    rd(3'h0, 3'h3, 16'h0000);
    // event landing on the clearing read
    wr(3'h0, 3'h1, 16'h7fff);
    wr(3'h0, 3'h2, 16'h7fff);
    fork
      ctl.xfer(1'b0, 3'h0, 3'h3, 16'h0000);
      begin
        tick(1);
        st[0][3] = ~st[0][3];
      end
    join
    rd(3'h0, 3'h3, 16'h0008);
    // operation summary up to a service request
    st[0] = 16'h0000;
    tick(2);
    ctl.xfer(1'b0, 3'h0, 3'h3, 16'h0000);
    wr(3'h0, 3'h4, 16'h0001);
    wr(3'h5, 3'h1, 16'h0080);
    wr(3'h5, 3'h2, 16'h0080);
    tick(1);
    st[0] = 16'h0001;
    tick(1);
    `CHK(status_byte, 8'h00)
    tick(1);
    `CHK({status_byte, service_request, srq_event, indiv_flag}, 11'h607)
    tick(1);
    `CHK(srq_event, 1'b0)
    rd(3'h0, 3'h3, 16'h0001);
    `CHK(status_byte, 8'h00)
    // message, error queue, request mask bit 6 ignored
    wr(3'h5, 3'h1, 16'h0054);
    wr(3'h5, 3'h2, 16'h0040);
    tick(1);
    msg_av = 1'b1;
    tick(1);
    `CHK({status_byte, srq_event, indiv_flag}, {8'h50, 2'b11})
    errq = 1'b1;
    tick(1);
    `CHK({status_byte, srq_event}, {8'h54, 1'b1})
    wr(3'h5, 3'h1, 16'h0040);
    tick(1);
    `CHK({status_byte, service_request, indiv_flag}, {8'h14, 2'b00})
    msg_av = 1'b0;
    errq = 1'b0;
    // standard events through their mask
    wr(3'h5, 3'h4, 16'h0001);
    std_ev = 8'h03;
    tick(1);
    std_ev = 8'h00;
    tick(1);
    `CHK(status_byte[5], 1'b1)
    rd(3'h5, 3'h3, 16'h0003);
    `CHK(status_byte[5], 1'b0)
    std_ev = 8'h02;
    tick(1);
    std_ev = 8'h00;
    tick(2);
    `CHK(status_byte[5], 1'b0)
    // limit group climbing through the questionable group
    wr(3'h2, 3'h1, 16'h7fff);
    wr(3'h2, 3'h4, 16'h0001);
    wr(3'h1, 3'h1, 16'h7fff);
    wr(3'h1, 3'h4, 16'h0200);
    wr(3'h5, 3'h2, 16'h0008);
    tick(1);
    st[2] = 16'h0001;
    tick(2);
    `CHK(status_byte[3], 1'b0)
    tick(1);
    `CHK({status_byte[3], indiv_flag}, 2'b11)
    // common registers read back unchanged, unmapped group reads zero
    rd(3'h5, 3'h0, 16'h0008);
    rd(3'h5, 3'h1, 16'h0040);
    rd(3'h5, 3'h2, 16'h0008);
    rd(3'h5, 3'h4, 16'h0001);
    rd(3'h5, 3'h5, 16'h0001);
    rd(3'h6, 3'h0, 16'h0000);
    rd(3'h1, 3'h3, 16'h0200);
    // group_a failure climbing through the questionable group
    wr(3'h4, 3'h1, 16'h7fff);
    wr(3'h4, 3'h4, 16'h0001);
    wr(3'h1, 3'h4, 16'h0800);
    tick(1);
    st[4] = 16'h0001;
    tick(3);
    `CHK(status_byte[3], 1'b1)
    rd(3'h1, 3'h3, 16'h0800);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
